// file: rirc_pkg.sv
// Shared constants, register layouts and types of the remote IR carrier codec.
// Assumes a single 40 MHz clock and 32-bit AXI4-Lite register access.
`default_nettype none

package rirc_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned CLK_KHZ = CLK_MHZ * 1000;
  localparam int unsigned PW_LO_US [4] = '{6000, 7000, 9000, 10600};
  localparam int unsigned PW_HI_US [4] = '{700, 800, 900, 1000};
  localparam int unsigned PW_CODE_BASE = 2;

  // ************************************************************
  // Register map: index, byte address is four times the index
  // ************************************************************
  localparam logic [5:0] IDX_RXC  = 6'h00;
  localparam logic [5:0] IDX_TXC  = 6'h01;
  localparam logic [5:0] IDX_CFG  = 6'h02;
  localparam logic [5:0] IDX_CTL  = 6'h08;
  localparam logic [5:0] IDX_STAT = 6'h09;
  localparam logic [7:0]  RXC_RST  = 8'h29;
  localparam logic [7:0]  TXC_RST  = 8'h69;
  localparam logic [7:0]  CFG_RST  = 8'h00;
  localparam logic [16:0] CTL_RST  = 17'h01f40;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0] tx_pulse_width_code;
    logic [4:0] tx_carrier_freq_code;
  } rirc_txc_t;

  typedef struct packed {
    logic [2:0] rx_band_range_code;
    logic [4:0] rx_carrier_freq_code;
  } rirc_rxc_t;

  typedef struct packed {
    logic       pulse_number_coding_en;
    logic       rx_oversample_sel;
    logic       rx_carrier_band_sel;
    logic       rsvd4;
    logic       tx_carrier_band_sel;
    logic       rx_decoder_bypass;
    logic [1:0] tx_modulation_mode;
  } rirc_cfg_t;

  typedef struct packed {
    logic        ask_ir_en;
    logic [15:0] baud_cycles;
  } rirc_ctl_t;

  typedef enum logic [1:0] {
    MM_CONT   = 2'h0,
    MM_PULSE8 = 2'h1,
    MM_PULSE6 = 2'h2,
    MM_RSVD   = 2'h3
  } rirc_mod_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_SEND = 2'h1
  } rirc_txst_t;

  localparam logic [3:0] PULSES_8 = 4'h8;
  localparam logic [3:0] PULSES_6 = 4'h6;

  // ************************************************************
  // Carrier frequencies (kHz) and receive windows (units of 0.1 kHz)
  // ************************************************************
  localparam logic [8:0] LO_FREQ_BASE_KHZ = 9'h01b;
  localparam logic [4:0] HI_CODE [3] = '{5'h03, 5'h08, 5'h0b};
  localparam logic [8:0] HI_KHZ  [3] = '{9'h190, 9'h1c2, 9'h1e0};
  localparam int unsigned HI_WIN_MIN [3] = '{3556, 3801, 4103};
  localparam int unsigned HI_WIN_MAX [3] = '{4571, 4898, 5274};
  localparam int unsigned ASK_WIN_MIN [6] = '{4800, 4571, 4364, 4174, 4000, 3840};
  localparam int unsigned ASK_WIN_MAX [6] = '{5333, 5647, 6000, 6400, 6856, 7385};
  localparam int unsigned LO_WIN_MIN = 300;
  localparam int unsigned LO_WIN_MAX = 560;
  localparam logic [2:0] HI_RANGE = 3'h1;
  localparam logic [4:0] OVS_SHIFT = 5'h04;
  localparam logic [4:0] OVS_HALF  = 5'h08;

  function automatic logic [10:0] rirc_per_cyc(input int unsigned khz10);
    rirc_per_cyc = 11'((CLK_KHZ * 10) / khz10);
  endfunction

endpackage

`default_nettype wire

// file: rirc_carrier_nco.sv
// Carrier generator: phase accumulator producing a square carrier.
// Assumes the frequency input is stable for the length of a burst.
`default_nettype none

module rirc_carrier_nco
  import rirc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [8:0] freq_khz,
  output logic            carrier,
  output logic            cycle_start
);

  // ************************************************************
  // Phase accumulator
  // ************************************************************
  // An accumulator avoids a divider; jitter is one clock of 25 ns.
  logic [16:0] phase_reg;
  logic [16:0] phase_next;
  logic        wrap_next;
  logic        wrap_reg;

  always_comb begin
    phase_next = phase_reg + 17'(freq_khz);
    wrap_next  = 1'b0;
    if (phase_next >= 17'(CLK_KHZ)) begin
      phase_next = phase_next - 17'(CLK_KHZ);
      wrap_next  = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg <= 17'h00000;
      wrap_reg  <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      wrap_reg  <= wrap_next;
    end
  end

  assign carrier     = (phase_reg < 17'(CLK_KHZ / 2));
  assign cycle_start = wrap_reg;

endmodule

`default_nettype wire

// file: rirc_band_detect.sv
// Carrier band-pass detector: measures rising-edge spacing of the input.
// Assumes the input is synchronous to the clock.
`default_nettype none

module rirc_band_detect
  import rirc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ir_in,
  input  wire logic [10:0] per_min,
  input  wire logic [10:0] per_max,
  output logic             carrier_present
);

  logic        prev_reg;
  logic [11:0] cnt_reg;
  logic [11:0] cnt_next;
  logic        pres_reg;
  logic        pres_next;
  logic        rise;

  assign rise = ir_in & ~prev_reg;

  always_comb begin
    cnt_next  = (cnt_reg == 12'hfff) ? cnt_reg : cnt_reg + 12'h001;
    pres_next = pres_reg;
    if (rise) begin
      cnt_next  = 12'h001;
      // Only an edge spacing inside the window keeps the carrier alive.
      pres_next = (cnt_reg >= {1'b0, per_min}) && (cnt_reg <= {1'b0, per_max});
    end else if (cnt_reg > {per_max, 1'b0}) begin
      pres_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_reg <= 1'b0;
      cnt_reg  <= 12'h000;
      pres_reg <= 1'b0;
    end else begin
      prev_reg <= ir_in;
      cnt_reg  <= cnt_next;
      pres_reg <= pres_next;
    end
  end

  assign carrier_present = pres_reg;

endmodule

`default_nettype wire

// file: rirc_top.sv
// Remote IR carrier codec: register file, transmit modulator, receive demodulator.
// Assumes an AXI4-Lite master, one IR front end, inputs synchronous to CLK.
//
// Implementation choice: the AXI4-Lite register port.
`default_nettype none

module rirc_top
  import rirc_pkg::*;
#(
  parameter int unsigned PW_CYC_LO [4] = '{PW_LO_US[0] * CLK_MHZ, PW_LO_US[1] * CLK_MHZ,
                                          PW_LO_US[2] * CLK_MHZ, PW_LO_US[3] * CLK_MHZ},
  parameter int unsigned PW_CYC_HI [4] = '{PW_HI_US[0] * CLK_MHZ, PW_HI_US[1] * CLK_MHZ,
                                          PW_HI_US[2] * CLK_MHZ, PW_HI_US[3] * CLK_MHZ}
)
(
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        TX_VALID,
  output logic             TX_READY,
  input  wire logic        TX_BIT,
  output logic             IR_TX,
  input  wire logic        IR_RX,
  output logic             RX_VALID,
  output logic             RX_BIT,
  output logic             RX_LEVEL
);

  // ************************************************************
  // Register file over AXI4-Lite
  // ************************************************************
  rirc_rxc_t   rxc_reg, rxc_next;
  rirc_txc_t   txc_reg, txc_next;
  rirc_cfg_t   cfg_reg, cfg_next;
  rirc_ctl_t   ctl_reg, ctl_next;
  logic        aw_got_reg, aw_got_next;
  logic        w_got_reg, w_got_next;
  logic [5:0]  waddr_reg, waddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic        wlane_reg, wlane_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic        tx_busy;
  logic        rx_present;

  assign S_AXI_AWREADY = ~aw_got_reg & ~bvalid_reg;
  assign S_AXI_WREADY  = ~w_got_reg & ~bvalid_reg;
  assign S_AXI_ARREADY = ~rvalid_reg;

  always_comb begin
    rxc_next    = rxc_reg;
    txc_next    = txc_reg;
    cfg_next    = cfg_reg;
    ctl_next    = ctl_reg;
    aw_got_next = aw_got_reg;
    w_got_next  = w_got_reg;
    waddr_next  = waddr_reg;
    wdata_next  = wdata_reg;
    wlane_next  = wlane_reg;
    bvalid_next = bvalid_reg;
    bresp_next  = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_got_next = 1'b1;
      waddr_next  = S_AXI_AWADDR[7:2];
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_got_next = 1'b1;
      wdata_next = S_AXI_WDATA;
      wlane_next = S_AXI_WSTRB[0];
    end
    if (aw_got_reg && w_got_reg) begin
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = RESP_OKAY;
      // Byte lane 0's strobe enables every write, the baud word in lanes 0 and 1 and ask_ir_en in lane 2 included.
      case (waddr_reg)
        IDX_RXC: if (wlane_reg) rxc_next = rirc_rxc_t'(wdata_reg[7:0]);
        IDX_TXC: if (wlane_reg) txc_next = rirc_txc_t'(wdata_reg[7:0]);
        IDX_CFG: if (wlane_reg) begin
          cfg_next       = rirc_cfg_t'(wdata_reg[7:0]);
          cfg_next.rsvd4 = 1'b0;
        end
        IDX_CTL: if (wlane_reg) ctl_next = rirc_ctl_t'(wdata_reg[16:0]);
        default: bresp_next = RESP_SLVERR;
      endcase
    end
    if (bvalid_reg && S_AXI_BREADY) begin
      bvalid_next = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      case (S_AXI_ARADDR[7:2])
        IDX_RXC:  rdata_next = {24'h000000, rxc_reg};
        IDX_TXC:  rdata_next = {24'h000000, txc_reg};
        IDX_CFG:  rdata_next = {24'h000000, cfg_reg};
        IDX_CTL:  rdata_next = {15'h0000, ctl_reg};
        IDX_STAT: rdata_next = {30'h00000000, rx_present, tx_busy};
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rxc_reg    <= rirc_rxc_t'(RXC_RST);
      txc_reg    <= rirc_txc_t'(TXC_RST);
      cfg_reg    <= rirc_cfg_t'(CFG_RST);
      ctl_reg    <= rirc_ctl_t'(CTL_RST);
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      waddr_reg  <= 6'h00;
      wdata_reg  <= 32'h00000000;
      wlane_reg  <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= RESP_OKAY;
    end else begin
      rxc_reg    <= rxc_next;
      txc_reg    <= txc_next;
      cfg_reg    <= cfg_next;
      ctl_reg    <= ctl_next;
      aw_got_reg <= aw_got_next;
      w_got_reg  <= w_got_next;
      waddr_reg  <= waddr_next;
      wdata_reg  <= wdata_next;
      wlane_reg  <= wlane_next;
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
    end
  end

  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP  = bresp_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA  = rdata_reg;
  assign S_AXI_RRESP  = rresp_reg;

  // ************************************************************
  // Transmit carrier and bit timing
  // ************************************************************
  logic [8:0]  tx_khz;
  logic [19:0] bit_cyc;
  logic [1:0]  pw_idx;
  logic        carrier;
  logic        cycle_start;

  always_comb begin
    tx_khz = HI_KHZ[0];
    if (!cfg_reg.tx_carrier_band_sel) begin
      tx_khz = LO_FREQ_BASE_KHZ + 9'(txc_reg.tx_carrier_freq_code);
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (txc_reg.tx_carrier_freq_code == HI_CODE[i]) begin
          tx_khz = HI_KHZ[i];
        end
      end
    end
  end

  // Reserved width codes fall back to the shortest listed width.
  assign pw_idx  = (txc_reg.tx_pulse_width_code >= 3'(PW_CODE_BASE) &&
                    txc_reg.tx_pulse_width_code <= 3'(PW_CODE_BASE + 3)) ?
                   2'(txc_reg.tx_pulse_width_code - 3'(PW_CODE_BASE)) : 2'h0;
  assign bit_cyc = cfg_reg.tx_carrier_band_sel ? 20'(PW_CYC_HI[pw_idx]) :
                                                20'(PW_CYC_LO[pw_idx]);

  rirc_carrier_nco u_nco (
    .clk         (CLK),
    .rst_b       (RST_B),
    .freq_khz    (tx_khz),
    .carrier     (carrier),
    .cycle_start (cycle_start)
  );

  // ************************************************************
  // Transmit modulator
  // ************************************************************
  rirc_txst_t  tx_st_reg, tx_st_next;
  logic [19:0] tx_cnt_reg, tx_cnt_next;
  logic [3:0]  pulse_reg, pulse_next;
  logic        energy_reg, energy_next;
  logic        irtx_reg, irtx_next;
  logic [3:0]  pulse_lim;
  rirc_mod_t   mode;

  assign mode      = rirc_mod_t'(cfg_reg.tx_modulation_mode);
  assign pulse_lim = (mode == MM_PULSE8) ? PULSES_8 : PULSES_6;
  assign TX_READY  = (tx_st_reg == TX_IDLE);
  assign tx_busy   = (tx_st_reg == TX_SEND);

  always_comb begin
    tx_st_next  = tx_st_reg;
    tx_cnt_next = tx_cnt_reg;
    pulse_next  = pulse_reg;
    energy_next = energy_reg;
    case (tx_st_reg)
      TX_IDLE: begin
        if (TX_VALID) begin
          tx_st_next  = TX_SEND;
          tx_cnt_next = bit_cyc;
          pulse_next  = 4'h0;
          // Energy level of a bit depends on the coding selection.
          energy_next = cfg_reg.pulse_number_coding_en ? ~TX_BIT : TX_BIT;
          if (mode == MM_RSVD) begin
            energy_next = 1'b0;
          end
        end
      end
      TX_SEND: begin
        tx_cnt_next = tx_cnt_reg - 20'h00001;
        if (cycle_start && energy_reg && mode != MM_CONT && pulse_reg <= pulse_lim) begin
          pulse_next = pulse_reg + 4'h1;
        end
        if (tx_cnt_reg <= 20'h00001) begin
          tx_st_next  = TX_IDLE;
          energy_next = 1'b0;
        end
      end
      default: begin
        tx_st_next  = TX_IDLE;
        energy_next = 1'b0;
      end
    endcase
    irtx_next = energy_reg & carrier & ((mode == MM_CONT) ||
                (pulse_reg + 4'(cycle_start) - 4'h1 < pulse_lim));
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_st_reg  <= TX_IDLE;
      tx_cnt_reg <= 20'h00000;
      pulse_reg  <= 4'h0;
      energy_reg <= 1'b0;
      irtx_reg   <= 1'b0;
    end else begin
      tx_st_reg  <= tx_st_next;
      tx_cnt_reg <= tx_cnt_next;
      pulse_reg  <= pulse_next;
      energy_reg <= energy_next;
      irtx_reg   <= irtx_next;
    end
  end

  assign IR_TX = irtx_reg;

  // ************************************************************
  // Receive window and carrier detection
  // ************************************************************
  logic [10:0] per_min;
  logic [10:0] per_max;

  always_comb begin
    per_min = rirc_per_cyc(LO_WIN_MAX);
    per_max = rirc_per_cyc(LO_WIN_MIN);
    if (cfg_reg.rx_carrier_band_sel && ctl_reg.ask_ir_en) begin
      for (int i = 0; i < 6; i++) begin
        if (rxc_reg.rx_band_range_code == 3'(i + 1)) begin
          per_min = rirc_per_cyc(ASK_WIN_MAX[i]);
          per_max = rirc_per_cyc(ASK_WIN_MIN[i]);
        end
      end
    end else if (cfg_reg.rx_carrier_band_sel && rxc_reg.rx_band_range_code == HI_RANGE) begin
      for (int i = 0; i < 3; i++) begin
        if (rxc_reg.rx_carrier_freq_code == HI_CODE[i]) begin
          per_min = rirc_per_cyc(HI_WIN_MAX[i]);
          per_max = rirc_per_cyc(HI_WIN_MIN[i]);
        end
      end
    end
  end

  rirc_band_detect u_det (
    .clk             (CLK),
    .rst_b           (RST_B),
    .ir_in           (IR_RX),
    .per_min         (per_min),
    .per_max         (per_max),
    .carrier_present (rx_present)
  );

  // ************************************************************
  // Receive sampler
  // ************************************************************
  // Bit slots run freely from reset; software aligns frames by content.
  logic [15:0] slot_reg, slot_next;
  logic [15:0] sub_reg, sub_next;
  logic [4:0]  ones_reg, ones_next;
  logic        mid_reg, mid_next;
  logic        rxv_reg, rxv_next;
  logic        rxb_reg, rxb_next;
  logic        lvl_reg, lvl_next;
  logic        energy;
  logic [15:0] sub_len;

  assign sub_len = ctl_reg.baud_cycles >> OVS_SHIFT;

  always_comb begin
    slot_next = slot_reg + 16'h0001;
    sub_next  = sub_reg + 16'h0001;
    ones_next = ones_reg;
    mid_next  = mid_reg;
    rxv_next  = 1'b0;
    rxb_next  = rxb_reg;
    lvl_next  = cfg_reg.rx_decoder_bypass ? IR_RX : rx_present;
    if (sub_reg >= sub_len) begin
      sub_next  = 16'h0000;
      ones_next = ones_reg + 5'(rx_present);
    end
    if (slot_reg == (ctl_reg.baud_cycles >> 1)) begin
      mid_next = rx_present;
    end
    if (slot_reg >= ctl_reg.baud_cycles - 16'h0001) begin
      slot_next = 16'h0000;
      sub_next  = 16'h0000;
      ones_next = 5'h00;
      rxv_next  = ~cfg_reg.rx_decoder_bypass;
      energy    = cfg_reg.rx_oversample_sel ? (ones_reg >= OVS_HALF) : mid_reg;
      if (!cfg_reg.rx_decoder_bypass) begin
        rxb_next = cfg_reg.pulse_number_coding_en ? ~energy : energy;
      end
    end else begin
      energy = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      slot_reg <= 16'h0000;
      sub_reg  <= 16'h0000;
      ones_reg <= 5'h00;
      mid_reg  <= 1'b0;
      rxv_reg  <= 1'b0;
      rxb_reg  <= 1'b0;
      lvl_reg  <= 1'b0;
    end else begin
      slot_reg <= slot_next;
      sub_reg  <= sub_next;
      ones_reg <= ones_next;
      mid_reg  <= mid_next;
      rxv_reg  <= rxv_next;
      rxb_reg  <= rxb_next;
      lvl_reg  <= lvl_next;
    end
  end

  assign RX_VALID = rxv_reg;
  assign RX_BIT   = rxb_reg;
  assign RX_LEVEL = lvl_reg;

endmodule

`default_nettype wire

// file: rirc_top_sva.sv
// Port checker of the remote IR carrier codec.
// Sees only rirc_top ports and is bound after its endmodule.
`default_nettype none
module rirc_top_sva
  import rirc_pkg::*;
#(
  parameter int unsigned PW_CYC_LO [4] = '{1, 1, 1, 1},
  parameter int unsigned PW_CYC_HI [4] = '{1, 1, 1, 1}
)
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic TX_VALID,
  input wire logic TX_READY,
  input wire logic IR_TX,
  input wire logic RX_VALID,
  input wire logic RX_BIT
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  // Counts busy cycles so a whole bit time is judged once, at its end.
  logic [15:0] busy_reg;
  logic [15:0] busy_next;
  always_comb begin
    busy_next = TX_READY ? 16'h0000 : busy_reg + 16'h0001;
  end
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      busy_reg <= 16'h0000;
    end else begin
      busy_reg <= busy_next;
    end
  end
  property p_rd_ans;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
  property p_wr_ans;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer missing");
  property p_b_once;
    S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID;
  endproperty
  a_b_once: assert property (p_b_once) else $error("write answer repeated");
  property p_idle_dark;
    TX_READY && $past(TX_READY) |-> !IR_TX;
  endproperty
  a_idle_dark: assert property (p_idle_dark) else $error("carrier while idle");
  property p_busy_start;
    $fell(TX_READY) |-> $past(TX_VALID);
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy without request");
  property p_busy_len;
    TX_READY && busy_reg != 16'h0000 |-> busy_reg inside {PW_CYC_LO, PW_CYC_HI};
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("bit time not in table");
  property p_rx_pulse;
    RX_VALID |=> !RX_VALID [*3];
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("receive pulse too long");
  property p_rx_hold;
    $changed(RX_BIT) |-> RX_VALID;
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("receive bit moved alone");
endmodule

bind rirc_top rirc_top_sva #(.PW_CYC_LO(PW_CYC_LO), .PW_CYC_HI(PW_CYC_HI))
  rirc_top_sva_i (.*);
`default_nettype wire

// file: rirc_ir_frontend.sv
// Model of the infrared front end: carrier source and transmit edge counter.
// Assumes ir_tx is synchronous to clk.
`default_nettype none
module rirc_ir_frontend
  import rirc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        light_on,
  input  wire logic [10:0] half_cyc,
  input  wire logic        ir_tx,
  input  wire logic        clr,
  output logic             ir_rx,
  output logic [15:0]      tx_edges
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [10:0] ph;
  logic        lvl;
  logic        tx_d;
  // The phase runs free and is only gated, so bursts start at any phase.
  assign ir_rx = light_on & lvl;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ph       <= 11'h000;
      lvl      <= 1'b0;
      tx_d     <= 1'b0;
      tx_edges <= 16'h0000;
    end else begin
      ph       <= (ph + 11'h001 >= half_cyc) ? 11'h000 : ph + 11'h001;
      lvl      <= (ph + 11'h001 >= half_cyc) ? ~lvl : lvl;
      tx_d     <= ir_tx;
      tx_edges <= clr ? 16'h0000 : tx_edges + 16'(ir_tx & ~tx_d);
    end
  end
endmodule
`default_nettype wire

// file: test_rirc_top.sv
// Self-checking bench of rirc_top with an IR front-end model.
// Pulse widths are shortened by parameter; one 40 MHz clock.
`default_nettype none
module test_rirc_top import rirc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned PW_LO [4] = '{400, 500, 600, 700};
  localparam int unsigned PW_HI [4] = '{1000, 1100, 1200, 1300};
  logic        CLK = 1'b0;
  logic        RST_B = 1'b0;
  logic [7:0]  S_AXI_AWADDR = 8'h00;
  logic [7:0]  S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0;
  logic        S_AXI_AWVALID = 1'b0;
  logic        S_AXI_WVALID = 1'b0;
  logic        S_AXI_BREADY = 1'b0;
  logic        S_AXI_ARVALID = 1'b0;
  logic        S_AXI_RREADY = 1'b0;
  logic        TX_VALID = 1'b0;
  logic        TX_BIT = 1'b0;
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic [31:0] S_AXI_RDATA;
  logic        TX_READY, IR_TX, IR_RX, RX_VALID, RX_BIT, RX_LEVEL, prev;
  logic        light_on = 1'b0;
  logic        clr = 1'b0;
  logic [10:0] half_cyc = 11'h032;
  logic [15:0] edges;
  logic [15:0] busy_cnt = 16'h0000;
  logic [33:0] exp_q [$];
  logic [31:0] d;
  int          mismatches = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          seed = 16;
  int          bad;
  logic [7:0]  pc [8] = '{8'h98, 8'ha6, 8'hd0, 8'he0, 8'hb0, 8'h58, 8'h10, 8'h8f};
  logic [16:0] rc [7] = '{17'h14832, 17'h04822, 17'h1f01d, 17'h0c81d, 17'h1c827,
                          17'h109f4, 17'h00832};

  initial begin
    forever #12.5 CLK = ~CLK;
  end
  rirc_top #(.PW_CYC_LO(PW_LO), .PW_CYC_HI(PW_HI)) rirc_top_i (.S_AXI_WSTRB(4'hf), .*);
  rirc_ir_frontend rirc_ir_frontend_i (.clk(CLK), .rst_b(RST_B), .light_on(light_on),
    .half_cyc(half_cyc), .ir_tx(IR_TX), .clr(clr), .ir_rx(IR_RX), .tx_edges(edges));

  // ********
  // Tasks
  // ********
  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // wr and rd end one edge after their handshake, tx two edges after TX_READY, so no strobe is set twice at once.
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= v;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while ((S_AXI_AWVALID && !S_AXI_AWREADY) || (S_AXI_WVALID && !S_AXI_WREADY));
    do @(posedge CLK); while (!S_AXI_BVALID);
    S_AXI_BREADY <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do @(posedge CLK); while (!S_AXI_ARREADY);
    S_AXI_ARVALID <= 1'b0;
    do @(posedge CLK); while (!S_AXI_RVALID);
    S_AXI_RREADY <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic tx(input logic b, input int unsigned n);
    exp_q.push_back(34'(n));
    TX_BIT <= b;
    TX_VALID <= 1'b1;
    clr <= 1'b1;
    @(posedge CLK);
    TX_VALID <= 1'b0;
    clr <= 1'b0;
    do @(posedge CLK); while (!TX_READY);
    repeat (2) @(posedge CLK);
  endtask
  task automatic conclude;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ********
  // Watcher and timeout
  // ********
  always @(posedge CLK) begin
    busy_cnt <= TX_READY ? 16'h0000 : busy_cnt + 16'h0001;
    cycles <= cycles + 1;
    if (S_AXI_BVALID && S_AXI_BREADY) cmp({S_AXI_BRESP, 32'h0}, exp_q.pop_front());
    else if (S_AXI_RVALID && S_AXI_RREADY) cmp({S_AXI_RRESP, S_AXI_RDATA}, exp_q.pop_front());
    else if (TX_READY && busy_cnt != 16'h0000) cmp(34'(busy_cnt), exp_q.pop_front());
    if (cycles == 90000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    repeat (12) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    rd({IDX_RXC, 2'b00}, {RESP_OKAY, 24'h0, RXC_RST});
    rd({IDX_TXC, 2'b00}, {RESP_OKAY, 24'h0, TXC_RST});
    rd({IDX_CFG, 2'b00}, {RESP_OKAY, 24'h0, CFG_RST});
    rd({IDX_CTL, 2'b00}, {RESP_OKAY, 15'h0, CTL_RST});
    rd(8'h0c, {RESP_SLVERR, 32'h0});
    wr({IDX_STAT, 2'b00}, 32'h3, RESP_SLVERR);
    rd({IDX_STAT, 2'b00}, {RESP_OKAY, 32'h0});
    d = $random(seed);
    wr({IDX_CFG, 2'b00}, d, RESP_OKAY);
    rd({IDX_CFG, 2'b00}, {RESP_OKAY, 24'h0, d[7:0] & 8'hef});
    $display("registers done");
    for (int i = 0; i < 8; i++) begin
      wr({IDX_CFG, 2'b00}, {28'h0, i[2], 3'b000}, RESP_OKAY);
      wr({IDX_TXC, 2'b00}, {24'h0, 3'(i[1:0] + 2), 5'h03}, RESP_OKAY);
      tx(1'b0, i[2] ? PW_HI[i % 4] : PW_LO[i % 4]);
    end
    $display("bit times done");
    wr({IDX_TXC, 2'b00}, {24'h0, 3'h2, 5'h03}, RESP_OKAY);
    foreach (pc[k]) begin
      wr({IDX_CFG, 2'b00}, {24'h0, pc[k][7], 4'h1, 1'b0, pc[k][5:4]}, RESP_OKAY);
      tx(pc[k][6], PW_HI[0]);
      cmp(34'((pc[k][3:0] == 4'hf && edges > 16'h0008) ? 16'h000f : edges),
          34'(pc[k][3:0]));
    end
    $display("modulation done");
    for (int k = 0; k < 7; k++) begin
      wr({IDX_RXC, 2'b00}, {24'h0, rc[k][13:11], 5'h03}, RESP_OKAY);
      wr({IDX_CTL, 2'b00}, {15'h0, rc[k][15], 16'h0190}, RESP_OKAY);
      wr({IDX_CFG, 2'b00}, {24'h0, 1'b1, 1'(k), rc[k][14], 5'h00}, RESP_OKAY);
      half_cyc <= rc[k][10:0];
      light_on <= 1'b1;
      repeat (3000) @(posedge CLK);
      rd({IDX_STAT, 2'b00}, {RESP_OKAY, 30'h0, rc[k][16], 1'b0});
      repeat (2) @(posedge CLK iff RX_VALID);
      cmp(34'(RX_BIT), 34'(!rc[k][16]));
    end
    $display("reception done");
    wr({IDX_CFG, 2'b00}, 32'h84, RESP_OKAY);
    bad = 0;
    prev = IR_RX;
    repeat (900) begin
      @(posedge CLK);
      bad = bad + int'(RX_VALID !== 1'b0) + int'(RX_LEVEL !== prev);
      prev = IR_RX;
    end
    cmp(34'(bad), 34'h0);
    $display("bypass done");
    conclude();
  end
endmodule
`default_nettype wire
